/* File: adc_glue_pkg.sv */
/*
 * Constants used by the converter bus port; its output buffer does not import them.
 * Assumes a single 25 MHz clock, mclk, and a synchronous active-high reset.
 */
package adc_glue_pkg;
    localparam int CLK_PERIOD_NS = 40;
    // Conversion time of the modelled core, in ns.
    localparam int CONV_TIME_NS = 4800;
    localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam logic [7:0] CONV_CYCLES_W = 8'(CONV_CYCLES);
    localparam int RESULT_W = 12;
    localparam int BUF_DEPTH = 2;
    localparam logic [11:0] RESULT_RESET = 12'h000;
    localparam logic [7:0] COUNT_RESET = 8'h00;

    typedef enum logic [2:0] {
        CONV_IDLE = 3'b001,
        CONV_BUSY = 3'b010,
        CONV_DONE = 3'b100
    } conv_state_type;
endpackage : adc_glue_pkg

/* File: result_if.sv */
/*
 * Valid/ready carrier for conversion results between the port and its buffer.
 * Assumes both ends run on mclk.
 */
`timescale 1ns/100ps
`default_nettype none
interface result_if;
    logic valid;
    logic ready;
    logic [11:0] data;
    modport source (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface : result_if
`default_nettype wire

/* File: result_buffer.sv */
/*
 * Two-entry flip-flop buffer between the converter core and the bus port.
 * Assumes one clock, synchronous active-high reset.
 */
`timescale 1ns/100ps
`default_nettype none
module result_buffer (
    input wire logic mclk,
    input wire logic rst,
    result_if.sink inp,
    result_if.source outp
);
    logic [11:0] mem_q [0:1];
    logic wrPtr_q;
    logic rdPtr_q;
    logic [1:0] count_q;
    logic push;
    logic pop;

    assign inp.ready = (count_q != 2'h2);
    assign outp.valid = (count_q != 2'h0);
    assign outp.data = mem_q[rdPtr_q];
    assign push = inp.valid && inp.ready;
    assign pop = outp.valid && outp.ready;

    always_ff @(posedge mclk) begin
        if (push) begin
            mem_q[wrPtr_q] <= inp.data;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wrPtr_q <= 1'b0;
            rdPtr_q <= 1'b0;
            count_q <= 2'h0;
        end else begin
            if (push) begin
                wrPtr_q <= ~wrPtr_q;
            end
            if (pop) begin
                rdPtr_q <= ~rdPtr_q;
            end
            count_q <= count_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : result_buffer
`default_nettype wire

/* File: adc_host_bus_glue.sv */
/*
 * Parallel host port of a 12-bit sampling converter: conversion start by
 * port write or external trigger, done flag and DMA request, and 8/12-bit
 * result reads with upper byte select.
 * Assumes host strobes are synchronous to mclk and the host keeps the
 * access spacing and wait-state glue on its own side.
 */
`timescale 1ns/100ps
`default_nettype none
module adc_host_bus_glue (
    input wire logic mclk,
    input wire logic rst,
    input wire logic start_convert_n,
    input wire logic ext_trigger,
    input wire logic chip_select_n,
    input wire logic read_enable_n,
    input wire logic upper_byte_select_n,
    input wire logic wide_bus_sel,
    input wire logic right_justify,
    input wire logic [11:0] sample_in,
    output logic [15:0] data_out,
    output logic data_out_en,
    output logic conversion_done,
    output logic dma_request_channel1,
    output logic conv_busy
);
    adc_glue_pkg::conv_state_type state_q;
    logic [7:0] cycleCount_q;
    logic [11:0] sample_q;
    logic trigPrev_q;
    logic startPrev_q;
    logic readPrev_q;
    logic lowRead_q;
    logic startReq;
    logic readAccess;
    logic readEnd;
    logic wordLeft;
    logic [11:0] rdData;
    logic [15:0] data_d;

    result_if coreSide ();
    result_if portSide ();

    // ************************************************************
    // Conversion start and timing
    // ************************************************************
    assign startReq = (!start_convert_n && startPrev_q)
        || (ext_trigger && !trigPrev_q);

    // Reset presets the start history to the idle level of its pin, so
    // no false start follows the release of reset.
    always_ff @(posedge mclk) begin
        if (rst) begin
            startPrev_q <= 1'b1;
            trigPrev_q <= 1'b0;
            readPrev_q <= 1'b0;
        end else begin
            startPrev_q <= start_convert_n;
            trigPrev_q <= ext_trigger;
            readPrev_q <= readAccess;
        end
    end

    // A start during a conversion is ignored; spacing is the host's job.
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= adc_glue_pkg::CONV_IDLE;
            cycleCount_q <= adc_glue_pkg::COUNT_RESET;
            sample_q <= adc_glue_pkg::RESULT_RESET;
        end else begin
            unique case (state_q)
                adc_glue_pkg::CONV_IDLE: begin
                    if (startReq) begin
                        sample_q <= sample_in;
                        cycleCount_q <= adc_glue_pkg::CONV_CYCLES_W - 8'h01;
                        state_q <= adc_glue_pkg::CONV_BUSY;
                    end
                end
                adc_glue_pkg::CONV_BUSY: begin
                    if (cycleCount_q == adc_glue_pkg::COUNT_RESET) begin
                        state_q <= adc_glue_pkg::CONV_DONE;
                    end else begin
                        cycleCount_q <= cycleCount_q - 8'h01;
                    end
                end
                adc_glue_pkg::CONV_DONE: begin
                    // With both entries full the result waits here, and
                    // further starts are ignored until it moves on.
                    if (coreSide.ready) begin
                        state_q <= adc_glue_pkg::CONV_IDLE;
                    end
                end
            endcase
        end
    end

    assign coreSide.valid = (state_q == adc_glue_pkg::CONV_DONE);
    assign coreSide.data = sample_q;

    // ************************************************************
    // Result buffering
    // ************************************************************
    // Two entries let one result wait while the host reads the previous.
    result_buffer resultBuf (
        .mclk(mclk),
        .rst(rst),
        .inp(coreSide),
        .outp(portSide)
    );

    // ************************************************************
    // Host read path
    // ************************************************************
    assign readAccess = !chip_select_n && !read_enable_n;
    // A word retires when a wide read ends, or when the low byte read ends.
    assign readEnd = readPrev_q && !readAccess && lowRead_q;
    assign portSide.ready = readEnd;
    assign rdData = portSide.data;

    // Left-justified low bytes carry four zero pad bits that an 8-bit host
    // must mask on its own side.
    always_comb begin
        data_d = 16'h0000;
        if (wide_bus_sel) begin
            data_d = {4'h0, rdData};
        end else if (!upper_byte_select_n) begin
            data_d = right_justify ? {8'h00, 4'h0, rdData[11:8]}
                : {8'h00, rdData[11:4]};
        end else begin
            data_d = right_justify ? {8'h00, rdData[7:0]}
                : {8'h00, rdData[3:0], 4'h0};
        end
    end

    // The drive enable lags the access by one cycle, like the data, so the
    // two never disagree on the bus.
    always_ff @(posedge mclk) begin
        if (rst) begin
            data_out <= 16'h0000;
            data_out_en <= 1'b0;
        end else begin
            data_out <= data_d;
            data_out_en <= readAccess;
        end
    end

    // ************************************************************
    // Byte tracking
    // ************************************************************
    // The host may drop the upper byte select in the same cycle that ends
    // the upper byte read. The byte kind is therefore held from the first
    // cycle of the access; the live select at the end would retire a word
    // whose low byte was never read.
    always_ff @(posedge mclk) begin
        if (rst) begin
            lowRead_q <= 1'b0;
        end else if (readAccess && !readPrev_q) begin
            lowRead_q <= wide_bus_sel || upper_byte_select_n;
        end
    end

    // ************************************************************
    // Done flag, DMA request and busy
    // ************************************************************
    // Only a result held in CONV_DONE keeps the request up after a clear; a word in the buffer's second entry drops it for a cycle.
    assign wordLeft = portSide.valid
        && !(readEnd && !coreSide.valid);

    always_ff @(posedge mclk) begin
        if (rst) begin
            conversion_done <= 1'b0;
        end else begin
            conversion_done <= wordLeft;
        end
    end

    // The request copies the done flag, so an interrupt-driven host and a
    // DMA channel see the same words waiting.
    always_ff @(posedge mclk) begin
        if (rst) begin
            dma_request_channel1 <= 1'b0;
        end else begin
            dma_request_channel1 <= wordLeft;
        end
    end

    // Busy rises with the accepted start, so the refusal window is visible
    // from the very next cycle.
    always_ff @(posedge mclk) begin
        if (rst) begin
            conv_busy <= 1'b0;
        end else begin
            conv_busy <= (state_q == adc_glue_pkg::CONV_BUSY)
                || (startReq && state_q == adc_glue_pkg::CONV_IDLE);
        end
    end
endmodule : adc_host_bus_glue
`default_nettype wire

/* File: adc_glue_assertions.sv */
/* Port checker for adc_host_bus_glue.
   Assumes one clock, mclk, and a synchronous active-high rst. */
`timescale 1ns/100ps
`default_nettype none
module adc_glue_assertions (
    input wire logic mclk,
    input wire logic rst,
    input wire logic start_convert_n,
    input wire logic ext_trigger,
    input wire logic chip_select_n,
    input wire logic read_enable_n,
    input wire logic upper_byte_select_n,
    input wire logic wide_bus_sel,
    input wire logic data_out_en,
    input wire logic conversion_done,
    input wire logic dma_request_channel1,
    input wire logic conv_busy
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    property p_dmaMirror;
        dma_request_channel1 == conversion_done;
    endproperty
    a_dmaMirror: assert property (p_dmaMirror)
        else $error("dma request differs from done");
    property p_startTaken;
        ($fell(start_convert_n) || $rose(ext_trigger)) && !conv_busy
            && !conversion_done |=> conv_busy;
    endproperty
    a_startTaken: assert property (p_startTaken)
        else $error("start not taken");
    property p_doneFollows;
        $fell(conv_busy) |-> ##[0:3] conversion_done;
    endproperty
    a_doneFollows: assert property (p_doneFollows)
        else $error("done missing after conversion");
    property p_busyHolds;
        $rose(conv_busy) |-> conv_busy[*8] ##1 !conversion_done;
    endproperty
    a_busyHolds: assert property (p_busyHolds)
        else $error("conversion ended early");
    property p_readAnswer;
        !chip_select_n && !read_enable_n |=> data_out_en;
    endproperty
    a_readAnswer: assert property (p_readAnswer)
        else $error("read not answered");
    property p_readRelease;
        chip_select_n || read_enable_n |=> !data_out_en;
    endproperty
    a_readRelease: assert property (p_readRelease)
        else $error("output enable stuck");
    property p_upperKeeps;
        conversion_done && !wide_bus_sel && !upper_byte_select_n
            && !chip_select_n && !read_enable_n |=> conversion_done;
    endproperty
    a_upperKeeps: assert property (p_upperKeeps)
        else $error("upper byte read retired word");
    property p_upperEnd;
        $rose(!chip_select_n && !read_enable_n) && !upper_byte_select_n
            && !wide_bus_sel && conversion_done |=> conversion_done[*3];
    endproperty
    a_upperEnd: assert property (p_upperEnd)
        else $error("end of upper byte read retired word");
endmodule : adc_glue_assertions
`default_nettype wire

/* File: host_model.sv */
/* Host processor side: start pulses and byte or word reads.
   Assumes callers enter the tasks just after a rising mclk edge. */
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input wire logic mclk,
    input wire logic [15:0] dataOut,
    output logic startN,
    output logic csN,
    output logic reN,
    output logic ubsN
);
    initial begin
        startN = 1'b1;
        csN = 1'b1;
        reN = 1'b1;
        ubsN = 1'b1;
    end
    // The pulse is short so start is never left low between conversions.
    task automatic startConv();
        startN <= 1'b0;
        repeat (2) @(posedge mclk);
        startN <= 1'b1;
    endtask : startConv
    // Each wait state stretches the access by one cycle; the data is taken
    // in the first, so a slower host sees the same byte.
    task automatic rd(input logic upper, input int waits,
        output logic [15:0] d);
        ubsN <= !upper;
        csN <= 1'b0;
        reN <= 1'b0;
        @(posedge mclk);
        #1 d = dataOut;
        repeat (waits) @(posedge mclk);
        csN <= 1'b1;
        reN <= 1'b1;
        ubsN <= 1'b1;
        @(posedge mclk);
    endtask : rd
endmodule : host_model
`default_nettype wire

/* File: testbench.sv */
/* Self-checking bench for adc_host_bus_glue with a host model.
   Assumes the 120-cycle conversion chosen in the package. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic mclk = 1'b0, rst = 1'b1, trig = 1'b0, wide = 1'b0, rj = 1'b0;
    logic startN, csN, reN, ubsN, en, done, dma, busy;
    logic [11:0] smp = 12'h000;
    logic [15:0] dOut, d;
    int n_mismatch = 0;
    int checks_done = 0;
    always #20 mclk = ~mclk;
    host_model u_host (.mclk(mclk), .dataOut(dOut), .startN(startN),
        .csN(csN), .reN(reN), .ubsN(ubsN));
    adc_host_bus_glue u_dut (.mclk(mclk), .rst(rst),
        .start_convert_n(startN), .ext_trigger(trig), .chip_select_n(csN),
        .read_enable_n(reN), .upper_byte_select_n(ubsN),
        .wide_bus_sel(wide), .right_justify(rj), .sample_in(smp),
        .data_out(dOut), .data_out_en(en), .conversion_done(done),
        .dma_request_channel1(dma), .conv_busy(busy));
    task automatic summarize();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : check
    task automatic convert(input logic [11:0] s, input logic useTrig);
        int i;
        repeat (10) @(posedge mclk);
        smp <= s;
        if (useTrig) begin
            trig <= 1'b1;
            repeat (2) @(posedge mclk);
            trig <= 1'b0;
        end else begin
            u_host.startConv();
        end
        @(negedge mclk);
        check(16'(busy), 16'h0001);
        for (i = 0; i < 200 && done !== 1'b1; i++) @(negedge mclk);
        check(16'({dma, done}), 16'h0003);
        if (done !== 1'b1) summarize();
        @(posedge mclk);
    endtask : convert
    task automatic doneIs(input logic v);
        @(negedge mclk);
        check(16'({dma, done}), {14'h0000, v, v});
        @(posedge mclk);
    endtask : doneIs
    task automatic wideRead();
        wide <= 1'b1;
        convert(12'hABC, 1'b0);
        u_host.rd(1'b0, 1, d);
        check(d, 16'h0ABC);
        doneIs(1'b0);
    endtask : wideRead
    task automatic byteRead(input logic r, input logic t, input int w,
        input logic [11:0] s, input logic [7:0] hi, input logic [7:0] lo);
        wide <= 1'b0;
        rj <= r;
        convert(s, t);
        u_host.rd(1'b1, w, d);
        check(d, {8'h00, hi});
        doneIs(1'b1);
        u_host.rd(1'b0, w, d);
        check(d, {8'h00, lo});
        doneIs(1'b0);
    endtask : byteRead
    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        @(negedge mclk);
        check(16'({en, done, dma, busy}), 16'h0000);
        repeat (250) @(posedge mclk);
        wideRead();
        byteRead(1'b0, 1'b0, 1, 12'h5A3, 8'h5A, 8'h30);
        byteRead(1'b1, 1'b1, 3, 12'hC3F, 8'h0C, 8'h3F);
        summarize();
    end
endmodule : testbench
bind adc_host_bus_glue adc_glue_assertions u_chk (.mclk(mclk), .rst(rst),
    .start_convert_n(start_convert_n), .ext_trigger(ext_trigger),
    .chip_select_n(chip_select_n), .read_enable_n(read_enable_n),
    .upper_byte_select_n(upper_byte_select_n),
    .wide_bus_sel(wide_bus_sel), .data_out_en(data_out_en),
    .conversion_done(conversion_done),
    .dma_request_channel1(dma_request_channel1), .conv_busy(conv_busy));
`default_nettype wire
